// File: design/pattern_group_update.sv
// next output value of one 4-bit pattern group
`timescale 1ns/100ps
module pattern_group_update (
    input wire logic [3:0] current,
    input wire logic [3:0] nextData,
    input wire logic [3:0] enable,
    input wire logic nonOverlap,
    input wire logic strobeA,
    input wire logic strobeB,
    output logic [3:0] updated
);
    logic [3:0] fallMask;
    logic [3:0] riseMask;

    always_comb begin
        fallMask = enable & current & ~nextData;
        riseMask = enable & ~current & nextData;
        updated = current;
        if (nonOverlap) begin
            // falling edges on match a, rising on match b: the gap is the guard
            if (strobeA) begin
                updated = updated & ~fallMask; // [RULE4]
            end
            if (strobeB) begin
                updated = updated | riseMask; // [RULE4]
            end
        end else if (strobeA) begin
            updated = (nextData & enable) | (current & ~enable); // [RULE17]
        end
    end
endmodule

// File: design/pattern_pkg.sv
// constants and bus carriers shared by the pattern output unit
package pattern_pkg;

    // bus address is a byte address; register index sits in bits 17:2
    localparam int ADDR_W = 18;
    localparam int INDEX_LSB = 2;
    localparam int INDEX_W = 16;

    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_MODE = 16'hffa0;
    localparam logic [15:0] IDX_TRIGGER_SELECT = 16'hffa1;
    localparam logic [15:0] IDX_ENABLE_HIGH = 16'hffa2;
    localparam logic [15:0] IDX_ENABLE_LOW = 16'hffa3;
    localparam logic [15:0] IDX_NEXT_HIGH = 16'hffa4;
    localparam logic [15:0] IDX_NEXT_LOW = 16'hffa5;
    localparam logic [15:0] IDX_NEXT_HIGH_ALT = 16'hffa6;
    localparam logic [15:0] IDX_NEXT_LOW_ALT = 16'hffa7;
    localparam logic [15:0] IDX_LOW_DIRECTION = 16'hffd1;
    localparam logic [15:0] IDX_LOW_OUTPUT = 16'hffd3;
    localparam logic [15:0] IDX_HIGH_DIRECTION = 16'hffd4;
    localparam logic [15:0] IDX_HIGH_OUTPUT = 16'hffd6;

    // reset values and fixed read values
    localparam logic [7:0] MODE_RESET = 8'hf0;
    localparam logic [7:0] TRIGGER_RESET = 8'hff;
    localparam logic [7:0] CLEAR_RESET = 8'h00;
    localparam logic [7:0] RESERVED_READ = 8'hff;
    localparam logic [3:0] RESERVED_NIBBLE = 4'hf;
    localparam logic [7:0] WRITE_ONLY_READ = 8'h00;

    // field layout
    localparam int MODE_NOV_LSB = 0;
    localparam int MODE_NOV_W = 4;
    localparam int SEL_W = 2;
    localparam int GROUP_W = 4;
    localparam int GROUPS = 4;
    localparam int CHANNELS = 4;
    localparam int PINS = 16;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } bus_req_t;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } bus_resp_t;

endpackage

// File: design/timing_pattern_output.sv
// pattern output unit: register file, trigger routing and port data
`timescale 1ns/100ps
// Operation
// RULE1: outputs form four 4-bit groups, each updating independently of the others.
// RULE2: sixteen pattern bits, each separately enabled for pattern output.
// RULE3: each group picks its trigger from four timer channel compare-matches.
// RULE4: non-overlap mode puts a guard gap between successive output transitions.
// RULE5: selected compare-matches also raise a dma request.
// RULE6: pins 0-3 group 0, 4-7 group 1, 8-11 group 2, 12-15 group 3.
// RULE7: low next byte at ffa5 when shared; split puts group 0 at ffa7.
// RULE8: high next byte at ffa4 when shared; split puts group 2 at ffa6.
// RULE9: software sets low port direction bits for pins used; register write-only.
// RULE10: software sets high port direction bits for pins used; register write-only.
// RULE11: low port data holds current pattern of groups 0 and 1.
// RULE12: high port data holds current pattern of groups 2 and 3.
// RULE13: low port data bits enabled for pattern output ignore writes.
// RULE14: high port data bits enabled for pattern output ignore writes.
// RULE15: reset sets mode register to f0 and trigger select to ff.
// RULE16: reset clears enables, next data, directions and port data.
// RULE17: on trigger enabled next bits copy to port; disabled bits hold.
// RULE18: shared trigger: upper nibble to higher group, lower to lower.
// RULE19: reserved next bits and unused alternate addresses ignore writes, read ones.
// RULE20: groups sharing a trigger update in the same clock cycle.
module timing_pattern_output (
    input wire logic clk,
    input wire logic reset,
    input wire pattern_pkg::bus_req_t busRequest,
    output pattern_pkg::bus_resp_t busResponse,
    input wire logic [3:0] compareMatchA,
    input wire logic [3:0] compareMatchB,
    output logic [15:0] patternPin,
    output logic [15:0] pinDirection,
    output logic [3:0] dmaRequest
);
    logic [3:0] noOverlap;
    logic [7:0] triggerSelect;
    logic [15:0] nextEnable;
    logic [15:0] nextPattern;
    logic [15:0] groupValue;
    logic [15:0] next_patternPin;
    logic [3:0] strobeA;
    logic [3:0] strobeB;
    logic [3:0] channelUsed;
    logic [15:0] wordIndex;
    logic [7:0] wdata;
    logic busWrite;
    logic sameLow;
    logic sameHigh;
    logic [7:0] readValue;

    function automatic logic pickChannel(input logic [1:0] sel, input logic [3:0] vec);
        pickChannel = vec[sel];
    endfunction

    assign wordIndex = busRequest.address[pattern_pkg::INDEX_LSB +: pattern_pkg::INDEX_W];
    assign wdata = busRequest.writedata[7:0];
    // a write lands only at the edge that completes the transfer
    assign busWrite = busRequest.write && !busResponse.waitrequest && busRequest.byteenable[0];
    assign sameLow = triggerSelect[1:0] == triggerSelect[3:2];
    assign sameHigh = triggerSelect[5:4] == triggerSelect[7:6];

    // per-group trigger routing and update
    genvar g;
    generate
        for (g = 0; g < pattern_pkg::GROUPS; g++) begin : grp
            logic [1:0] sel;
            assign sel = triggerSelect[g*pattern_pkg::SEL_W +: pattern_pkg::SEL_W];
            assign strobeA[g] = pickChannel(sel, compareMatchA); // [RULE3]
            assign strobeB[g] = pickChannel(sel, compareMatchB); // [RULE3]
            pattern_group_update update (
                .current(patternPin[g*4 +: 4]), // [RULE6]
                .nextData(nextPattern[g*4 +: 4]),
                .enable(nextEnable[g*4 +: 4]),
                .nonOverlap(noOverlap[g]),
                .strobeA(strobeA[g]),
                .strobeB(strobeB[g]),
                .updated(groupValue[g*4 +: 4]) // [RULE1]
            );
        end
    endgenerate

    // a channel raises dma only while some enabled group listens to it
    always_comb begin
        channelUsed = 4'h0;
        for (int c = 0; c < pattern_pkg::CHANNELS; c++) begin
            for (int k = 0; k < pattern_pkg::GROUPS; k++) begin
                if (triggerSelect[k*2 +: 2] == c[1:0] && |nextEnable[k*4 +: 4]) begin
                    channelUsed[c] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dmaRequest <= 4'h0;
        end else begin
            dmaRequest <= compareMatchA & channelUsed; // [RULE5]
        end
    end

    // port data: software owns disabled bits, the groups own enabled ones
    always_comb begin
        next_patternPin = patternPin;
        if (busWrite && wordIndex == pattern_pkg::IDX_LOW_OUTPUT) begin
            next_patternPin[7:0] = (wdata & ~nextEnable[7:0]) |
                (patternPin[7:0] & nextEnable[7:0]); // [RULE13]
        end
        if (busWrite && wordIndex == pattern_pkg::IDX_HIGH_OUTPUT) begin
            next_patternPin[15:8] = (wdata & ~nextEnable[15:8]) |
                (patternPin[15:8] & nextEnable[15:8]); // [RULE14]
        end
        // all enabled bits land on one edge
        next_patternPin = (next_patternPin & ~nextEnable) | (groupValue & nextEnable); // [RULE20]
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            patternPin <= {pattern_pkg::CLEAR_RESET, pattern_pkg::CLEAR_RESET}; // [RULE16]
        end else begin
            patternPin <= next_patternPin; // [RULE11] [RULE12]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pinDirection <= {pattern_pkg::CLEAR_RESET, pattern_pkg::CLEAR_RESET}; // [RULE16]
        end else if (busWrite && wordIndex == pattern_pkg::IDX_LOW_DIRECTION) begin
            pinDirection[7:0] <= wdata;
        end else if (busWrite && wordIndex == pattern_pkg::IDX_HIGH_DIRECTION) begin
            pinDirection[15:8] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            noOverlap <= pattern_pkg::MODE_RESET[pattern_pkg::MODE_NOV_LSB +: 4]; // [RULE15]
            triggerSelect <= pattern_pkg::TRIGGER_RESET; // [RULE15]
        end else if (busWrite && wordIndex == pattern_pkg::IDX_MODE) begin
            noOverlap <= wdata[pattern_pkg::MODE_NOV_LSB +: pattern_pkg::MODE_NOV_W];
        end else if (busWrite && wordIndex == pattern_pkg::IDX_TRIGGER_SELECT) begin
            triggerSelect <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            nextEnable <= {pattern_pkg::CLEAR_RESET, pattern_pkg::CLEAR_RESET}; // [RULE16]
        end else if (busWrite && wordIndex == pattern_pkg::IDX_ENABLE_HIGH) begin
            nextEnable[15:8] <= wdata;
        end else if (busWrite && wordIndex == pattern_pkg::IDX_ENABLE_LOW) begin
            nextEnable[7:0] <= wdata; // [RULE2]
        end
    end

    // next data: address layout follows whether paired groups share a trigger
    always_ff @(posedge clk) begin
        if (reset) begin
            nextPattern[7:0] <= pattern_pkg::CLEAR_RESET; // [RULE16]
        end else if (busWrite && wordIndex == pattern_pkg::IDX_NEXT_LOW) begin
            if (sameLow) begin
                nextPattern[7:0] <= wdata; // [RULE7] [RULE18]
            end else begin
                nextPattern[7:4] <= wdata[7:4]; // [RULE7] [RULE19]
            end
        end else if (busWrite && wordIndex == pattern_pkg::IDX_NEXT_LOW_ALT && !sameLow) begin
            nextPattern[3:0] <= wdata[3:0]; // [RULE7] [RULE19]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            nextPattern[15:8] <= pattern_pkg::CLEAR_RESET; // [RULE16]
        end else if (busWrite && wordIndex == pattern_pkg::IDX_NEXT_HIGH) begin
            if (sameHigh) begin
                nextPattern[15:8] <= wdata; // [RULE8] [RULE18]
            end else begin
                nextPattern[15:12] <= wdata[7:4]; // [RULE8] [RULE19]
            end
        end else if (busWrite && wordIndex == pattern_pkg::IDX_NEXT_HIGH_ALT && !sameHigh) begin
            nextPattern[11:8] <= wdata[3:0]; // [RULE8] [RULE19]
        end
    end

    // read view; direction registers are write-only and read as zero
    always_comb begin
        unique case (wordIndex)
            pattern_pkg::IDX_MODE: begin
                readValue = {pattern_pkg::RESERVED_NIBBLE, noOverlap};
            end
            pattern_pkg::IDX_TRIGGER_SELECT: begin
                readValue = triggerSelect;
            end
            pattern_pkg::IDX_ENABLE_HIGH: begin
                readValue = nextEnable[15:8];
            end
            pattern_pkg::IDX_ENABLE_LOW: begin
                readValue = nextEnable[7:0];
            end
            pattern_pkg::IDX_NEXT_HIGH: begin
                readValue = sameHigh ? nextPattern[15:8] :
                    {nextPattern[15:12], pattern_pkg::RESERVED_NIBBLE}; // [RULE19]
            end
            pattern_pkg::IDX_NEXT_HIGH_ALT: begin
                readValue = sameHigh ? pattern_pkg::RESERVED_READ :
                    {pattern_pkg::RESERVED_NIBBLE, nextPattern[11:8]}; // [RULE19]
            end
            pattern_pkg::IDX_NEXT_LOW: begin
                readValue = sameLow ? nextPattern[7:0] :
                    {nextPattern[7:4], pattern_pkg::RESERVED_NIBBLE}; // [RULE19]
            end
            pattern_pkg::IDX_NEXT_LOW_ALT: begin
                readValue = sameLow ? pattern_pkg::RESERVED_READ :
                    {pattern_pkg::RESERVED_NIBBLE, nextPattern[3:0]}; // [RULE19]
            end
            pattern_pkg::IDX_LOW_OUTPUT: begin
                readValue = patternPin[7:0];
            end
            pattern_pkg::IDX_HIGH_OUTPUT: begin
                readValue = patternPin[15:8];
            end
            default: begin
                readValue = pattern_pkg::WRITE_ONLY_READ;
            end
        endcase
    end

    // one wait state: data is captured the edge before completion
    always_ff @(posedge clk) begin
        if (reset) begin
            busResponse.waitrequest <= 1'b1;
            busResponse.readdata <= 32'h0000_0000;
        end else if ((busRequest.read || busRequest.write) && busResponse.waitrequest) begin
            busResponse.waitrequest <= 1'b0;
            busResponse.readdata <= {24'h00_0000, readValue};
        end else begin
            busResponse.waitrequest <= 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_RESET_MODE: assert property ( // [RULE15]
        $past(reset) |-> (noOverlap == 4'h0 && triggerSelect == 8'hff))
        else $error("mode or trigger select wrong after reset");

    AST_RESET_CLEAR: assert property ( // [RULE16]
        $past(reset) |-> (patternPin == 16'h0000 && nextPattern == 16'h0000 &&
            nextEnable == 16'h0000 && pinDirection == 16'h0000))
        else $error("registers not cleared after reset");

    AST_LOW_LOCKED: assert property ( // [RULE13]
        (busWrite && wordIndex == pattern_pkg::IDX_LOW_OUTPUT && strobeA == 4'h0 &&
            strobeB == 4'h0) |=> ((patternPin[7:0] & $past(nextEnable[7:0])) ==
            ($past(patternPin[7:0]) & $past(nextEnable[7:0]))))
        else $error("enabled low port bit changed by a write");

    AST_HIGH_WRITABLE: assert property ( // [RULE14]
        (busWrite && wordIndex == pattern_pkg::IDX_HIGH_OUTPUT && strobeA == 4'h0 &&
            strobeB == 4'h0) |=> (patternPin[15:8] == (($past(wdata) &
            ~$past(nextEnable[15:8])) | ($past(patternPin[15:8]) & $past(nextEnable[15:8])))))
        else $error("high port write not applied to free bits only");

    AST_SHARED_ALT_IGNORED: assert property ( // [RULE7]
        (busWrite && wordIndex == pattern_pkg::IDX_NEXT_LOW_ALT && sameLow) |=>
            $stable(nextPattern[7:0]))
        else $error("alternate low next address written while shared");

    AST_SPLIT_HIGH: assert property ( // [RULE8]
        (busWrite && wordIndex == pattern_pkg::IDX_NEXT_HIGH && !sameHigh) |=>
            (nextPattern[11:8] == $past(nextPattern[11:8]) &&
            nextPattern[15:12] == $past(wdata[7:4])))
        else $error("split high next byte written wrongly");

    AST_RESERVED_READ: assert property ( // [RULE19]
        (busRequest.read && busResponse.waitrequest && sameLow &&
            wordIndex == pattern_pkg::IDX_NEXT_LOW_ALT) |=>
            (!busResponse.waitrequest && busResponse.readdata == 32'h0000_00ff))
        else $error("unused alternate address did not read ones");

    AST_ATOMIC_LOW: assert property ( // [RULE20]
        (sameLow && strobeA[0] && noOverlap[1:0] == 2'h0 && nextEnable[7:0] == 8'hff)
            |=> (patternPin[7:0] == $past(nextPattern[7:0])))
        else $error("shared groups did not update together");

    AST_DMA: assert property ( // [RULE5]
        (compareMatchA[0] && channelUsed[0]) |=> dmaRequest[0] ##1 (!dmaRequest[0] ||
            $past(compareMatchA[0] && channelUsed[0])))
        else $error("dma request not raised by selected compare-match");

    AST_HOLD_DISABLED: assert property ( // [RULE2]
        (nextEnable[3:0] == 4'h0 && !busWrite) |=> $stable(patternPin[3:0]))
        else $error("disabled pattern bits changed");

    AST_SPLIT_LOW: assert property ( // [RULE7]
        (busWrite && wordIndex == pattern_pkg::IDX_NEXT_LOW_ALT && !sameLow) |=>
            (nextPattern[3:0] == $past(wdata[3:0]) &&
            nextPattern[7:4] == $past(nextPattern[7:4])))
        else $error("split low next byte written wrongly");

    AST_SHARED_HIGH_ALT_IGNORED: assert property ( // [RULE8]
        (busWrite && wordIndex == pattern_pkg::IDX_NEXT_HIGH_ALT && sameHigh) |=>
            $stable(nextPattern[15:8]))
        else $error("alternate high next address written while shared");

    AST_SHARED_HIGH: assert property ( // [RULE18]
        (busWrite && wordIndex == pattern_pkg::IDX_NEXT_HIGH && sameHigh) |=>
            (nextPattern[15:8] == $past(wdata)))
        else $error("shared high next byte not stored whole");

    // match b alone may only raise enabled bits that the next data asks for
    AST_RISE_ON_B: assert property ( // [RULE4]
        (strobeB[0] && !strobeA[0] && noOverlap[0] && !busWrite) |=>
            (patternPin[3:0] == ($past(patternPin[3:0]) |
            ($past(nextEnable[3:0]) & $past(nextPattern[3:0])))))
        else $error("non-overlap group 0 did not rise on match b");

    AST_DIR_WRITE: assert property ( // [RULE10]
        (busWrite && wordIndex == pattern_pkg::IDX_HIGH_DIRECTION) |=>
            (pinDirection[15:8] == $past(wdata)))
        else $error("high direction write not stored");

    AST_UNUSED_NO_DMA: assert property ( // [RULE5]
        (!channelUsed[1]) |=> !dmaRequest[1])
        else $error("dma raised on a channel no enabled group uses");

    generate
        for (g = 0; g < pattern_pkg::GROUPS; g++) begin : chk
            AST_LOAD: assert property ( // [RULE17]
                (strobeA[g] && !noOverlap[g] && nextEnable[g*4 +: 4] == 4'hf) |=>
                    (patternPin[g*4 +: 4] == $past(nextPattern[g*4 +: 4])))
                else $error("enabled group bits did not load next data");

            AST_NO_RISE_ON_A: assert property ( // [RULE4]
                (strobeA[g] && !strobeB[g] && noOverlap[g]) |=>
                    ((patternPin[g*4 +: 4] & ~$past(patternPin[g*4 +: 4])) == 4'h0))
                else $error("non-overlap group rose on match a");
        end
    endgenerate

    COV_SHARED_LOAD: cover property (sameLow && strobeA[0] && nextEnable[7:0] != 8'h00);
    COV_SPLIT_HIGH: cover property (!sameHigh && strobeA[3] && !strobeA[2]);
    COV_NON_OVERLAP: cover property (noOverlap[0] && strobeA[0] ##[1:20] strobeB[0]);
    COV_DMA: cover property (dmaRequest != 4'h0);
endmodule

// File: verification/test_timing_pattern_output.sv
// self-checking bench for the pattern output unit
`timescale 1ns/100ps
module test_timing_pattern_output;
    logic clk = 1'b0;
    logic reset = 1'b1;
    pattern_pkg::bus_req_t busReq = '0;
    pattern_pkg::bus_resp_t busResp;
    logic [3:0] kickA = 4'h0;
    logic [3:0] kickB = 4'h0;
    logic [3:0] gap = 4'h0;
    logic [3:0] matchA;
    logic [3:0] matchB;
    logic [15:0] patternPin;
    logic [15:0] pinDirection;
    logic [3:0] dmaRequest;
    int err_count = 0;
    int compares = 0;
    logic [15:0] pins;
    logic [15:0] en;
    logic [15:0] nxt;
    logic [15:0] w;
    logic [7:0] sel;
    logic [3:0] nov;
    logic [3:0] dma;
    int c;

    always #5 clk = ~clk;

    timing_pattern_output i_timing_pattern_output (.clk(clk), .reset(reset),
        .busRequest(busReq), .busResponse(busResp), .compareMatchA(matchA),
        .compareMatchB(matchB), .patternPin(patternPin), .pinDirection(pinDirection),
        .dmaRequest(dmaRequest));
    timer_model i_timer_model (.clk(clk), .reset(reset), .kickA(kickA), .kickB(kickB),
        .gap(gap), .matchA(matchA), .matchB(matchB));

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one bus transfer; request held until waitrequest is sampled low
    task automatic access(input logic [15:0] idx, input logic wr, input logic [7:0] d,
                          output logic [7:0] rd);
        int n;
        @(posedge clk);
        busReq.address <= {idx, 2'b00};
        busReq.read <= !wr;
        busReq.write <= wr;
        busReq.writedata <= {24'h0, d};
        busReq.byteenable <= 4'hf;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busResp.waitrequest !== 1'b0 && n < 40);
        rd = busResp.readdata[7:0];
        busReq.read <= 1'b0;
        busReq.write <= 1'b0;
        if (n >= 40) begin
            err_count++;
            conclude();
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] rd;
        access(idx, 1'b1, d, rd);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] rd;
        access(idx, 1'b0, 8'h00, rd);
        check(what, {8'h00, rd}, {8'h00, exp});
    endtask

    // split triggers move the lower group to the alternate address
    task automatic nextPair(input logic [15:0] main, input logic [15:0] alt,
                            input logic shared, input logic [7:0] v);
        if (shared) begin
            wr(main, v);
            wr(alt, 8'h00);
        end else begin
            wr(main, {v[7:4], ~v[3:0]});
            wr(alt, {~v[7:4], v[3:0]});
        end
        rdc(main, shared ? v : {v[7:4], 4'hf}, "next main");
        rdc(alt, shared ? 8'hff : {4'hf, v[3:0]}, "next alt");
    endtask

    function automatic logic [3:0] nib(input logic [3:0] cur, input logic [3:0] nx,
            input logic [3:0] e, input logic nv, input logic ha, input logic hb);
        logic [3:0] r;
        r = cur;
        if (ha)
            r = nv ? (r & ~(e & ~nx)) : ((r & ~e) | (nx & e));
        if (hb && nv)
            r = r | (e & nx);
        return r;
    endfunction

    // strobe via the timer model, then compare pins and dma one edge later
    task automatic fire(input logic [3:0] a, input logic [3:0] b);
        int n;
        @(posedge clk);
        kickA <= a;
        kickB <= b;
        gap <= 4'($urandom % 4);
        @(posedge clk);
        kickA <= 4'h0;
        kickB <= 4'h0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((matchA | matchB) === 4'h0 && n < 20);
        if (n >= 20) begin
            err_count++;
            conclude();
        end
        dma = 4'h0;
        for (int g = 0; g < 4; g++) begin
            if (a[sel[2*g +: 2]] && en[4*g +: 4] != 4'h0)
                dma[sel[2*g +: 2]] = 1'b1;
            pins[4*g +: 4] = nib(pins[4*g +: 4], nxt[4*g +: 4], en[4*g +: 4], nov[g],
                                 a[sel[2*g +: 2]], b[sel[2*g +: 2]]);
        end
        @(posedge clk);
        check("pins", patternPin, pins);
        check("dma", {12'h0, dmaRequest}, {12'h0, dma});
    endtask

    initial begin
        void'($urandom(68));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rdc(pattern_pkg::IDX_MODE, 8'hf0, "mode");
        rdc(pattern_pkg::IDX_TRIGGER_SELECT, 8'hff, "trigger");
        rdc(pattern_pkg::IDX_ENABLE_HIGH, 8'h00, "enable high");
        rdc(pattern_pkg::IDX_ENABLE_LOW, 8'h00, "enable low");
        rdc(pattern_pkg::IDX_NEXT_HIGH, 8'h00, "next high");
        rdc(pattern_pkg::IDX_NEXT_LOW, 8'h00, "next low");
        rdc(pattern_pkg::IDX_LOW_OUTPUT, 8'h00, "low out");
        rdc(pattern_pkg::IDX_HIGH_OUTPUT, 8'h00, "high out");
        rdc(pattern_pkg::IDX_NEXT_LOW_ALT, 8'hff, "low alt");
        check("dir", pinDirection, 16'h0000);
        check("pins", patternPin, 16'h0000);
        $display("test reset done");
        wr(pattern_pkg::IDX_LOW_DIRECTION, 8'hff);
        wr(pattern_pkg::IDX_HIGH_DIRECTION, 8'hff);
        @(posedge clk);
        check("dir", pinDirection, 16'hffff);
        rdc(pattern_pkg::IDX_LOW_DIRECTION, 8'h00, "dir read");
        wr(16'hffb0, 8'h5a);
        rdc(16'hffb0, 8'h00, "unmapped");
        $display("test direction done");
        for (int i = 0; i < 12; i++) begin
            sel = (i == 0) ? 8'he4 : (i == 1) ? 8'h55 : 8'($urandom);
            nov = (i < 6) ? 4'h0 : 4'($urandom);
            en = (i == 1) ? 16'hffff : 16'($urandom);
            nxt = 16'($urandom);
            w = 16'($urandom);
            wr(pattern_pkg::IDX_ENABLE_LOW, 8'h00);
            wr(pattern_pkg::IDX_ENABLE_HIGH, 8'h00);
            wr(pattern_pkg::IDX_LOW_OUTPUT, w[7:0]);
            wr(pattern_pkg::IDX_HIGH_OUTPUT, w[15:8]);
            pins = w;
            @(posedge clk);
            check("port data", patternPin, pins);
            wr(pattern_pkg::IDX_MODE, {4'h0, nov});
            rdc(pattern_pkg::IDX_MODE, {4'hf, nov}, "mode");
            wr(pattern_pkg::IDX_TRIGGER_SELECT, sel);
            rdc(pattern_pkg::IDX_TRIGGER_SELECT, sel, "trigger");
            wr(pattern_pkg::IDX_ENABLE_LOW, en[7:0]);
            wr(pattern_pkg::IDX_ENABLE_HIGH, en[15:8]);
            rdc(pattern_pkg::IDX_ENABLE_HIGH, en[15:8], "enable");
            nextPair(pattern_pkg::IDX_NEXT_LOW, pattern_pkg::IDX_NEXT_LOW_ALT,
                     sel[1:0] == sel[3:2], nxt[7:0]);
            nextPair(pattern_pkg::IDX_NEXT_HIGH, pattern_pkg::IDX_NEXT_HIGH_ALT,
                     sel[5:4] == sel[7:6], nxt[15:8]);
            w = 16'($urandom);
            wr(pattern_pkg::IDX_LOW_OUTPUT, w[7:0]);
            wr(pattern_pkg::IDX_HIGH_OUTPUT, w[15:8]);
            pins = (pins & en) | (w & ~en);
            rdc(pattern_pkg::IDX_LOW_OUTPUT, pins[7:0], "low out");
            rdc(pattern_pkg::IDX_HIGH_OUTPUT, pins[15:8], "high out");
            // corner 1 has every group on channel 1, so fire that channel
            c = (i == 1) ? 1 : int'($urandom % 4);
            fire(4'h1 << c, 4'h0);
            fire(4'h0, 4'h1 << c);
            $display("test pattern %0d done", i);
        end
        conclude();
    end
endmodule

// File: verification/timer_model.sv
// timer stand-in: compare-match strobes, sent promptly or after a delay
`timescale 1ns/100ps
module timer_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] kickA,
    input wire logic [3:0] kickB,
    input wire logic [3:0] gap,
    output logic [3:0] matchA,
    output logic [3:0] matchB
);
    logic [3:0] pendA;
    logic [3:0] pendB;
    logic [3:0] count;

    // strobes last exactly one cycle, as a real timer's would
    always_ff @(posedge clk) begin
        matchA <= 4'h0;
        matchB <= 4'h0;
        if (reset) begin
            pendA <= 4'h0;
            pendB <= 4'h0;
            count <= 4'h0;
        end else if ((kickA | kickB) != 4'h0) begin
            pendA <= kickA;
            pendB <= kickB;
            count <= gap;
        end else if ((pendA | pendB) != 4'h0) begin
            if (count == 4'h0) begin
                matchA <= pendA;
                matchB <= pendB;
                pendA <= 4'h0;
                pendB <= 4'h0;
            end else begin
                count <= count - 4'h1;
            end
        end
    end
endmodule
